/* File: hdl/serial_prog_readback_verify.sv */
// Contract
// - each read returns one byte; programmer pairs two bytes per word
// - table pointer post-increment wraps to zero past the last code byte
// - config bytes read with the table-read command, compared byte by byte
// - eeprom read via low/high address registers and an 8-bit data latch
// - two core payloads clear program and config select bits to pick eeprom
// - setting the read bit copies the addressed eeprom byte into the latch
// - shift-out command drives the table latch onto the data pin
// - after the 8th falling operand clock the pin turns to output
// - shift-out: first payload byte undefined, second carries the data
// - erased cells read as ones, blank bytes return ff
// - unused configuration bits read back as zero
// - config bytes stay readable under read or code protection
// - eight user id bytes at consecutive addresses in the id region
// - command lsb first; byte out in the last eight clocks, lsb first
// - each table read advances the 22-bit pointer by one, except from the last code byte, where it wraps to zero
`timescale 1ns/1ps
module serial_prog_readback_verify import prog_pkg::*; #(
    parameter int CODE_BYTES = 65536,
    parameter int EE_BYTES = 256,
    parameter logic [7:0] DEVID1_VALUE = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVID2_VALUE = 8'ha5  // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data_in,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe
);
    localparam int CAW = $clog2(CODE_BYTES + ID_COUNT);
    localparam int EAW = $clog2(EE_BYTES);

    typedef struct packed {
        phase_t phase;
        logic [4:0] cnt;
        logic [3:0] cmd;
        logic [15:0] pay;
        logic clk_d;
        logic [7:0] wreg;
        logic [7:0] eeprom_addr_low;
        logic [7:0] eeprom_addr_high;
        logic [7:0] eeprom_data_latch;
        logic [7:0] table_latch;
        logic [21:0] tblptr;
        logic program_space_select;
        logic config_space_select;
        logic [7:0] osh;
        logic dout;
        logic doe;
        logic en;
        logic [1:0] region;
        logic [21:0] maddr;
        logic [7:0] wdat;
        logic code_we;
        logic ee_we;
        logic [CFG_COUNT-1:0][7:0] cfg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t s_ff;
    state_t nxt_s;
    logic [1:0] pins;
    logic sclk;
    logic sdat;

    mem_port_if #(.AW(CAW)) code_if();
    mem_port_if #(.AW(EAW)) ee_if();

    // two flops on both pins before anything looks at them
    pin_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({prog_serial_data_in, prog_serial_clock}),
        .dout(pins)
    );
    assign sclk = pins[0];
    assign sdat = pins[1];

    // code memory with the eight id bytes stacked above it
    nv_array #(.DEPTH(CODE_BYTES + ID_COUNT), .AW(CAW)) u_code (
        .pclk(pclk),
        .port(code_if.store)
    );

    nv_array #(.DEPTH(EE_BYTES), .AW(EAW)) u_eeprom (
        .pclk(pclk),
        .port(ee_if.store)
    );

    // table pointer to code array index; id bytes sit after code
    function automatic logic [CAW-1:0] code_index(input logic [21:0] ptr);
        if (ptr < 22'(CODE_BYTES)) begin
            return CAW'(ptr);
        end
        return CAW'(CODE_BYTES) + CAW'(ptr[2:0]);
    endfunction

    function automatic logic is_id(input logic [21:0] ptr);
        return ptr[21:3] == ID_BASE[21:3];
    endfunction

    // byte seen by a table read; no protection gate on config
    function automatic logic [7:0] table_byte(input logic [21:0] ptr, input logic [7:0] code_rd,
                                              input logic [CFG_COUNT-1:0][7:0] cfg);
        logic [21:0] off;
        off = ptr - CFG_BASE;
        if (ptr < 22'(CODE_BYTES) || is_id(ptr)) begin
            return code_rd;
        end
        if (ptr >= CFG_BASE && off < 22'(CFG_COUNT)) begin
            return cfg[off[3:0]] & CFG_MASK[off[3:0]];
        end
        if (ptr == DEVID_BASE) begin
            return DEVID1_VALUE;
        end
        if (ptr == DEVID_BASE + 22'd1) begin
            return DEVID2_VALUE;
        end
        return UNMAPPED_BYTE;
    endfunction

    // post-increment wraps to zero only at the last code byte; any other address just adds one
    function automatic logic [21:0] ptr_next(input logic [21:0] ptr);
        if (ptr == 22'(CODE_BYTES - 1)) begin
            return '0;
        end
        return ptr + 22'd1;
    endfunction

    function automatic logic cmd_reads(input logic [3:0] cmd);
        return cmd == CMD_TBLRD_INC || cmd == CMD_SHIFT_OUT;
    endfunction

    always_comb begin
        logic rise;
        logic fall;
        logic [4:0] inc;
        logic [15:0] word;
        logic [7:0] opc;
        logic [7:0] lit;
        logic [7:0] rd_byte;
        logic bit_val;
        logic [7:0] a;
        rise = sclk & ~s_ff.clk_d;
        fall = ~sclk & s_ff.clk_d;
        inc = s_ff.cnt + 5'd1;
        word = {sdat, s_ff.pay[15:1]};
        opc = word[15:8];
        lit = word[7:0];
        bit_val = opc[7:4] == OPC_BSF;
        a = paddr[7:0];
        // one byte per read: table byte or the table latch
        rd_byte = (s_ff.cmd == CMD_TBLRD_INC) ?
            table_byte(s_ff.tblptr, code_if.rdata, s_ff.cfg) : s_ff.table_latch;

        nxt_s = s_ff;
        nxt_s.clk_d = sclk;
        nxt_s.code_we = 1'b0;
        nxt_s.ee_we = 1'b0;
        nxt_s.pready = 1'b0;
        nxt_s.pslverr = 1'b0;

        // serial engine; disabled port returns to command phase, pin released
        if (!s_ff.en) begin
            nxt_s.phase = PH_CMD;
            nxt_s.cnt = '0;
            nxt_s.doe = 1'b0;
        end else if (fall) begin
            unique case (s_ff.phase)
                PH_CMD: begin
                    nxt_s.cmd = {sdat, s_ff.cmd[3:1]};
                    nxt_s.cnt = inc;
                    if (inc == CMD_BITS) begin
                        nxt_s.phase = PH_PAYLOAD;
                        nxt_s.cnt = '0;
                    end
                end
                PH_PAYLOAD: begin
                    nxt_s.pay = word;
                    nxt_s.cnt = inc;
                    // turn the pin at the 8th fall; first byte stays undriven
                    if (inc == OPERAND_BITS && cmd_reads(s_ff.cmd)) begin
                        nxt_s.osh = rd_byte;
                        nxt_s.dout = rd_byte[0];
                        nxt_s.doe = 1'b1;
                    end
                    if (inc == PAYLOAD_BITS) begin
                        nxt_s.phase = PH_CMD;
                        nxt_s.cnt = '0;
                        nxt_s.doe = 1'b0;
                        if (s_ff.cmd == CMD_TBLRD_INC) begin
                            nxt_s.tblptr = ptr_next(s_ff.tblptr);
                        end
                        if (s_ff.cmd == CMD_CORE) begin
                            if (opc == OPC_MOVLW) begin
                                nxt_s.wreg = lit;
                            end else if (opc == OPC_MOVWF) begin
                                unique case (lit)
                                    F_TABLE_PTR_UPPER: nxt_s.tblptr[21:16] = s_ff.wreg[5:0];
                                    F_TABLE_PTR_HIGH: nxt_s.tblptr[15:8] = s_ff.wreg;
                                    F_TABLE_PTR_LOW: nxt_s.tblptr[7:0] = s_ff.wreg;
                                    F_EEPROM_ADDR_LOW: nxt_s.eeprom_addr_low = s_ff.wreg;
                                    F_EEPROM_ADDR_HIGH: nxt_s.eeprom_addr_high = s_ff.wreg;
                                    F_TABLE_LATCH: nxt_s.table_latch = s_ff.wreg;
                                    default: ;
                                endcase
                            end else if (opc == OPC_MOVF_W && lit == F_EEPROM_DATA_LATCH) begin
                                nxt_s.wreg = s_ff.eeprom_data_latch;
                            end else if ((bit_val || opc[7:4] == OPC_BCF) && lit == F_MEMORY_CONTROL) begin
                                if (opc[3:1] == BIT_PROGRAM_SPACE) begin
                                    nxt_s.program_space_select = bit_val;
                                end
                                if (opc[3:1] == BIT_CONFIG_SPACE) begin
                                    nxt_s.config_space_select = bit_val;
                                end
                                // read bit self-clears, so it is not stored
                                if (opc[3:1] == BIT_READ && bit_val && !s_ff.program_space_select
                                    && !s_ff.config_space_select) begin
                                    nxt_s.eeprom_data_latch = ee_if.rdata;
                                end
                            end
                        end
                    end
                end
            endcase
        end else if (rise && s_ff.doe && s_ff.cnt > OPERAND_BITS) begin
            // next bit on the rise, programmer samples late in the high phase
            nxt_s.osh = {1'b0, s_ff.osh[7:1]};
            nxt_s.dout = s_ff.osh[1];
        end

        // loader address steps on the same edge that performs each memory write
        if (s_ff.code_we || s_ff.ee_we) begin
            nxt_s.maddr = s_ff.maddr + 22'd1;
        end

        // apb setup: answer in the following access cycle
        if (psel && !penable) begin
            nxt_s.pready = 1'b1;
            nxt_s.prdata = '0;
            unique case (a)
                REG_CTRL: nxt_s.prdata = {31'h0, s_ff.en};
                REG_TBLPTR: nxt_s.prdata = {10'h0, s_ff.tblptr};
                REG_STATUS: nxt_s.prdata = {4'h0, s_ff.phase == PH_PAYLOAD, s_ff.doe, s_ff.config_space_select,
                                            s_ff.program_space_select, s_ff.wreg, s_ff.table_latch,
                                            s_ff.eeprom_data_latch};
                REG_MEM_ADDR: nxt_s.prdata = {s_ff.region, 8'h0, s_ff.maddr};
                REG_MEM_DATA: nxt_s.prdata = '0;
                default: nxt_s.pslverr = 1'b1;
            endcase
        end

        // writes land at the access edge only
        if (psel && penable && s_ff.pready && pwrite && !s_ff.pslverr) begin
            unique case (a)
                REG_CTRL: nxt_s.en = pwdata[0];
                REG_MEM_ADDR: begin
                    nxt_s.region = pwdata[31:30];
                    nxt_s.maddr = pwdata[21:0];
                end
                REG_MEM_DATA: begin
                    nxt_s.wdat = pwdata[7:0];
                    if (s_ff.region == REGION_CODE && (s_ff.maddr < 22'(CODE_BYTES) || is_id(s_ff.maddr))) begin
                        nxt_s.code_we = 1'b1;
                    end
                    if (s_ff.region == REGION_EEPROM && s_ff.maddr < 22'(EE_BYTES)) begin
                        nxt_s.ee_we = 1'b1;
                    end
                    if (s_ff.region == REGION_CONFIG && s_ff.maddr < 22'(CFG_COUNT)) begin
                        nxt_s.cfg[s_ff.maddr[3:0]] = pwdata[7:0];
                        nxt_s.maddr = s_ff.maddr + 22'd1;
                    end
                end
                default: ;
            endcase
        end
    end

    // config comes up erased; memories keep their contents over reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.cfg <= {CFG_COUNT{ERASED_BYTE}};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // memory ports: read follows the pointers, write follows the loader
    assign code_if.raddr = code_index(s_ff.tblptr);
    assign code_if.waddr = code_index(s_ff.maddr);
    assign code_if.wdata = s_ff.wdat;
    assign code_if.we = s_ff.code_we;
    assign ee_if.raddr = EAW'({s_ff.eeprom_addr_high, s_ff.eeprom_addr_low});
    assign ee_if.waddr = s_ff.maddr[EAW-1:0];
    assign ee_if.wdata = s_ff.wdat;
    assign ee_if.we = s_ff.ee_we;

    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign prog_serial_data_out = s_ff.dout;
    assign prog_serial_data_oe = s_ff.doe;
endmodule

/* File: hdl/prog_pkg.sv */
package prog_pkg;
    // pclk rate
    localparam int CLK_NS = 5;

    // serial frame shape, counted in falling edges of the programming clock
    localparam logic [4:0] CMD_BITS = 5'd4;
    localparam logic [4:0] OPERAND_BITS = 5'd8;
    localparam logic [4:0] PAYLOAD_BITS = 5'd16;

    // 4-bit commands
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_SHIFT_OUT = 4'h2;
    localparam logic [3:0] CMD_TBLRD_INC = 4'h9;

    // core instruction opcodes (upper payload byte)
    localparam logic [7:0] OPC_MOVLW = 8'h0e;
    localparam logic [7:0] OPC_MOVWF = 8'h6e;
    localparam logic [7:0] OPC_MOVF_W = 8'h50;
    localparam logic [3:0] OPC_BSF = 4'h8;
    localparam logic [3:0] OPC_BCF = 4'h9;

    // core file addresses (lower payload byte)
    localparam logic [7:0] F_TABLE_PTR_UPPER = 8'hf8;
    localparam logic [7:0] F_TABLE_PTR_HIGH = 8'hf7;
    localparam logic [7:0] F_TABLE_PTR_LOW = 8'hf6;
    localparam logic [7:0] F_TABLE_LATCH = 8'hf5;
    localparam logic [7:0] F_EEPROM_ADDR_LOW = 8'ha9;
    localparam logic [7:0] F_EEPROM_ADDR_HIGH = 8'haa;
    localparam logic [7:0] F_EEPROM_DATA_LATCH = 8'ha8;
    localparam logic [7:0] F_MEMORY_CONTROL = 8'ha6;

    // bit numbers inside memory_control_reg
    localparam logic [2:0] BIT_PROGRAM_SPACE = 3'd7;
    localparam logic [2:0] BIT_CONFIG_SPACE = 3'd6;
    localparam logic [2:0] BIT_READ = 3'd0;

    // address map of the table pointer
    localparam logic [21:0] ID_BASE = 22'h200000;
    localparam int ID_COUNT = 8;
    localparam logic [21:0] CFG_BASE = 22'h300000;
    localparam int CFG_COUNT = 14;
    localparam logic [21:0] DEVID_BASE = 22'h3ffffe;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

    // implemented configuration bits, index 0 at the right
    localparam logic [CFG_COUNT-1:0][7:0] CFG_MASK = {
        8'h40, 8'h3f, 8'he0, 8'h3f, 8'hc0, 8'h3f, 8'h00,
        8'hc5, 8'h87, 8'h00, 8'h1f, 8'h3f, 8'hcf, 8'h3f};

    // apb register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TBLPTR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MEM_ADDR = 8'h0c;
    localparam logic [7:0] REG_MEM_DATA = 8'h10;

    // image load regions in REG_MEM_ADDR[31:30]
    localparam logic [1:0] REGION_CODE = 2'h0;
    localparam logic [1:0] REGION_EEPROM = 2'h1;
    localparam logic [1:0] REGION_CONFIG = 2'h2;

    typedef enum logic {PH_CMD, PH_PAYLOAD} phase_t;
endpackage

/* File: hdl/mem_port_if.sv */
`timescale 1ns/1ps
interface mem_port_if #(parameter int AW = 8);
    logic [AW-1:0] raddr;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] rdata;
    modport user(output raddr, output waddr, output wdata, output we, input rdata);
    modport store(input raddr, input waddr, input wdata, input we, output rdata);
endinterface

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync import prog_pkg::*; #(
    parameter int W = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t s_ff;
    sync_t nxt_s;

    // first stage feeds only the second
    always_comb begin
        nxt_s.s1 = din;
        nxt_s.s2 = s_ff.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dout = s_ff.s2;
endmodule

/* File: hdl/nv_array.sv */
`timescale 1ns/1ps
module nv_array import prog_pkg::*; #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic pclk,
    mem_port_if.store port
);
    logic [7:0] cells [DEPTH];
    logic [7:0] rdata_ff;

    // erased cells come up as ones
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            cells[i] = ERASED_BYTE;
        end
    end

    // registered read, written only by the image loader
    always_ff @(posedge pclk) begin
        if (port.we) begin
            cells[port.waddr] <= port.wdata;
        end
        rdata_ff <= cells[port.raddr];
    end

    assign port.rdata = rdata_ff;
endmodule

/* File: verif/serial_prog_readback_verify_sva.sv */
`timescale 1ns/1ps
module serial_prog_readback_verify_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data_out,
    input wire logic prog_serial_data_oe
);
    logic clk_q_ff;
    logic [3:0] rises_ff;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // count link clock rises while the pin is driven; raw sampling is fine, phases are long
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q_ff <= 1'b0;
            rises_ff <= 4'h0;
        end else begin
            clk_q_ff <= prog_serial_clock;
            if (!prog_serial_data_oe)
                rises_ff <= 4'h0;
            else if (prog_serial_clock && !clk_q_ff)
                rises_ff <= rises_ff + 4'h1;
        end
    end

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error with data");
    a_oe_turnaround: assert property ($rose(prog_serial_data_oe) |-> !prog_serial_clock)
        else $error("pin turned while clock high");
    a_bit_after_rise: assert property (prog_serial_data_oe && $past(prog_serial_data_oe) &&
        $changed(prog_serial_data_out) |-> prog_serial_clock)
        else $error("output bit changed on low clock");
    a_release_count: assert property ($fell(prog_serial_data_oe) |-> rises_ff == 4'h8)
        else $error("pin driven for wrong bit count");
    a_release_low: assert property ($fell(prog_serial_data_oe) |-> !prog_serial_clock)
        else $error("pin released on high clock");
endmodule

bind serial_prog_readback_verify serial_prog_readback_verify_sva u_serial_prog_readback_verify_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_serial_clock(prog_serial_clock),
    .prog_serial_data_out(prog_serial_data_out), .prog_serial_data_oe(prog_serial_data_oe));

/* File: verif/prog_host_model.sv */
`timescale 1ns/1ps
module prog_host_model import prog_pkg::*; (
    input wire logic pclk,
    input wire logic dev_out,
    input wire logic dev_oe,
    output logic sclk,
    output logic sdata
);
    logic drv_en = 1'b1;
    logic drv_val = 1'b0;
    logic junk_ff = 1'b0;

    // a released pin shows a toggling pattern, never the last bit
    always @(posedge pclk) begin
        junk_ff <= ~junk_ff;
    end
    assign sdata = dev_oe ? dev_out : (drv_en ? drv_val : junk_ff);

    initial begin
        sclk = 1'b0;
    end

    // 4 command bits then 16 payload bits, lsb first; 32 pclk (160 ns) link clock
    task automatic frame(input logic [3:0] cmd, input logic [15:0] pay, output logic [7:0] rd);
        logic [19:0] bits;
        logic rdcmd;
        bits = {pay, cmd};
        rdcmd = (cmd == CMD_TBLRD_INC) || (cmd == CMD_SHIFT_OUT);
        rd = 8'h00;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            sclk <= 1'b1;
            if (i >= 12 && rdcmd) begin
                // sample late in the high phase, long after the device has shifted
                repeat (15) @(posedge pclk);
                rd[i-12] = sdata;
                @(posedge pclk);
            end else begin
                repeat (8) @(posedge pclk);
                drv_en <= 1'b1;
                drv_val <= bits[i];
                repeat (8) @(posedge pclk);
            end
            sclk <= 1'b0;
            if (i == 11 && rdcmd) begin
                drv_en <= 1'b0; // hand the pin over
            end
            repeat (15) @(posedge pclk); // low phase also serves as turnaround hold
        end
    endtask
endmodule

/* File: verif/serial_prog_readback_verify_tb.sv */
`timescale 1ns/1ps
module serial_prog_readback_verify_tb import prog_pkg::*; ;
    localparam int CODE_N = 1024;
    localparam logic [7:0] DEV1 = 8'h3c; // arbitrary value
    localparam logic [7:0] DEV2 = 8'hc3; // arbitrary value
    `define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, sclk, sdin, sdout, soe, e;
    int fails = 0;
    int n_checks = 0;
    integer seed = 85721;
    logic [7:0] rb, exp_b, ea;
    logic [7:0] code_b [3];
    logic [7:0] id_b [8];

    serial_prog_readback_verify #(.CODE_BYTES(CODE_N), .DEVID1_VALUE(DEV1), .DEVID2_VALUE(DEV2))
    u_serial_prog_readback_verify (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_serial_clock(sclk), .prog_serial_data_in(sdin), .prog_serial_data_out(sdout),
        .prog_serial_data_oe(soe));
    prog_host_model u_prog_host_model (.pclk(pclk), .dev_out(sdout), .dev_oe(soe), .sclk(sclk), .sdata(sdin));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // registered answer is settled mid-cycle and stands up to the next rising edge
        do begin
            @(negedge pclk);
            n++;
            rdy = pready;
            rd = prdata;
            err = pslverr;
            @(posedge pclk);
        end while (rdy !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (rdy !== 1'b1) begin
            fails++;
            final_report();
        end
    endtask

    // image load: address then byte
    task automatic load(input logic [1:0] region, input logic [21:0] a, input logic [7:0] d);
        apb(1'b1, REG_MEM_ADDR, {region, 8'h00, a}, rv, e);
        apb(1'b1, REG_MEM_DATA, {24'h0, d}, rv, e);
    endtask

    task automatic core(input logic [15:0] p);
        logic [7:0] r;
        u_prog_host_model.frame(CMD_CORE, p, r);
    endtask

    task automatic tblrd(output logic [7:0] r);
        u_prog_host_model.frame(CMD_TBLRD_INC, 16'h0000, r);
    endtask

    task automatic set_ptr(input logic [21:0] a);
        core({OPC_MOVLW, 2'b00, a[21:16]});
        core({OPC_MOVWF, F_TABLE_PTR_UPPER});
        core({OPC_MOVLW, a[15:8]});
        core({OPC_MOVWF, F_TABLE_PTR_HIGH});
        core({OPC_MOVLW, a[7:0]});
        core({OPC_MOVWF, F_TABLE_PTR_LOW});
    endtask

    // full eeprom read sequence ending in a shift-out
    task automatic ee_read(input logic [7:0] a, output logic [7:0] r);
        core({OPC_BCF, BIT_PROGRAM_SPACE, 1'b0, F_MEMORY_CONTROL});
        core({OPC_BCF, BIT_CONFIG_SPACE, 1'b0, F_MEMORY_CONTROL});
        core({OPC_MOVLW, a});
        core({OPC_MOVWF, F_EEPROM_ADDR_LOW});
        core({OPC_MOVLW, 8'h00});
        core({OPC_MOVWF, F_EEPROM_ADDR_HIGH});
        core({OPC_BSF, BIT_READ, 1'b0, F_MEMORY_CONTROL});
        core({OPC_MOVF_W, F_EEPROM_DATA_LATCH});
        core({OPC_MOVWF, F_TABLE_LATCH});
        core(16'h0000);
        u_prog_host_model.frame(CMD_SHIFT_OUT, 16'h0000, r);
    endtask

    function automatic logic [7:0] exp_cfg(input logic [7:0] raw, input int i);
        return raw & CFG_MASK[i];
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog well beyond the ~290 us the sequence needs
    initial begin
        #450000;
        fails++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset state and a refused access
        apb(1'b0, REG_STATUS, 32'h0, rv, e);
        `CHECK(rv, 32'h0)
        apb(1'b0, 8'h40, 32'h0, rv, e);
        `CHECK({e, rv}, 33'h100000000)
        apb(1'b1, REG_CTRL, 32'h1, rv, e);
        $display("test reset done");
        // pointer wraps past the last code byte
        for (int i = 0; i < 3; i++) begin
            code_b[i] = 8'($random(seed));
            load(REGION_CODE, 22'((CODE_N - 2 + i) % CODE_N), code_b[i]);
        end
        set_ptr(22'(CODE_N - 2));
        for (int i = 0; i < 3; i++) begin
            tblrd(rb);
            `CHECK(rb, code_b[i])
        end
        apb(1'b0, REG_TBLPTR, 32'h0, rv, e);
        `CHECK(rv[21:0], 22'h1)
        set_ptr(22'h5);
        tblrd(rb);
        `CHECK(rb, ERASED_BYTE)
        $display("test code done");
        // id region, explicit reload after code
        for (int i = 0; i < 8; i++) begin
            id_b[i] = {4'hf, 4'($random(seed))};
            load(REGION_CODE, ID_BASE + 22'(i), id_b[i]);
        end
        set_ptr(ID_BASE);
        for (int i = 0; i < 9; i++) begin
            tblrd(rb);
            `CHECK(rb, (i < 8) ? id_b[i] : UNMAPPED_BYTE)
        end
        $display("test id done");
        // eeprom written byte, then its blank neighbour
        ea = 8'($random(seed));
        exp_b = 8'($random(seed));
        load(REGION_EEPROM, {14'h0, ea}, exp_b);
        ee_read(ea, rb);
        `CHECK(rb, exp_b)
        apb(1'b0, REG_STATUS, 32'h0, rv, e);
        `CHECK(rv[15:0], {exp_b, exp_b})
        ee_read(ea + 8'h1, rb);
        `CHECK(rb, ERASED_BYTE)
        // set path of the program select bit, never reached by the read sequence
        core({OPC_BSF, BIT_PROGRAM_SPACE, 1'b0, F_MEMORY_CONTROL});
        apb(1'b0, REG_STATUS, 32'h0, rv, e);
        `CHECK(rv[25:24], 2'b01)
        $display("test eeprom done");
        // blank configuration, then config byte 5 written and read back
        set_ptr(CFG_BASE);
        for (int i = 0; i < CFG_COUNT; i++) begin
            tblrd(rb);
            `CHECK(rb, exp_cfg(ERASED_BYTE, i))
        end
        exp_b = 8'($random(seed));
        load(REGION_CONFIG, 22'h5, exp_b);
        set_ptr(CFG_BASE + 22'h5);
        tblrd(rb);
        `CHECK(rb, exp_cfg(exp_b, 5))
        // identity bytes, left out of the blank check
        set_ptr(DEVID_BASE);
        tblrd(rb);
        `CHECK(rb, DEV1)
        tblrd(rb);
        `CHECK(rb, DEV2)
        $display("test config done");
        final_report();
    end
endmodule
